// *** hw/irq_accept.sv ***
// Interrupt acceptance, masking, priority and exception entry sequencing.
`timescale 1ns/10ps
module irq_accept
	import irq_accept_pkg::*;
(
	input  wire logic                            core_clk,
	input  wire logic                            reset,
	input  wire logic                            standby,
	input  wire logic                            nmi_event,
	input  wire logic [irq_accept_pkg::N_SRC-1:0] src_flag,
	input  wire logic [irq_accept_pkg::N_SRC-1:0] src_enable,
	input  wire logic [irq_accept_pkg::N_SRC-1:0] priority_level_bits,
	input  wire logic                            mask_scheme_select,
	input  wire irq_accept_pkg::mem_type         mem_kind,
	input  wire logic [1:0]                      wait_states,
	input  wire logic                            insn_done,
	input  wire logic [irq_accept_pkg::PC_W-1:0] return_pc,
	input  wire logic                            flags_write,
	input  wire irq_accept_pkg::flags_type       flags_wdata,
	input  wire logic [irq_accept_pkg::PC_W-1:0] vector_data,
	output irq_accept_pkg::flags_type            condition_flags,
	output logic                                 cpu_request,
	output logic                                 stack_push,
	output irq_accept_pkg::frame_type            stack_frame,
	output logic                                 vector_read,
	output logic [irq_accept_pkg::VADDR_W-1:0]   vector_addr,
	output logic                                 pc_load,
	output logic [irq_accept_pkg::PC_W-1:0]      new_pc,
	output logic                                 accept_valid,
	output logic                                 accept_nmi,
	output logic [irq_accept_pkg::ID_W-1:0]      accept_id
);
	import irq_accept_pkg::*;

	state_type           state_reg, state_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	flags_type           flags_reg, flags_next;
	logic                nmi_pend_reg, nmi_pend_next;
	logic                sel_nmi_reg, sel_nmi_next;
	logic [ID_W-1:0]     sel_id_reg, sel_id_next;
	frame_type           frame_reg, frame_next;
	logic [PC_W-1:0]     handler_reg, handler_next;
	logic                push_reg, push_next;
	logic                vread_reg, vread_next;
	logic [VADDR_W-1:0]  vaddr_reg, vaddr_next;
	logic                pcld_reg, pcld_next;
	logic                acc_reg, acc_next;
	logic                busy_reg, busy_next;

	logic [N_SRC-1:0]    req;
	logic                cand_valid;
	logic [ID_W-1:0]     cand_id;
	logic                cand_allowed;
	logic [CNT_W-1:0]    phase_len;
	logic [7:0]          sel_vector;

	// Enable gating per source
	// RULE_04 per source enable
	genvar g;
	generate
		for (g = 0; g < N_SRC; g++) begin : gen_req
			assign req[g] = src_flag[g] & src_enable[g];
		end
	endgenerate

	// Level 1 requests scan last and override level 0; within a level the lowest index, which is the
	// smallest vector, wins. Re-evaluated every cycle so a withdrawn source drops out.
	// RULE_05 RULE_06 RULE_07 RULE_08 RULE_24 priority select
	always_comb begin
		cand_valid = 1'b0;
		cand_id    = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (req[i] && !priority_level_bits[i]) begin
				cand_valid = 1'b1;
				cand_id    = ID_W'(i);
			end
		end
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (req[i] && priority_level_bits[i]) begin
				cand_valid = 1'b1;
				cand_id    = ID_W'(i);
			end
		end
	end

	// Mask check on the selected request only, others stay pending.
	always_comb begin
		if (mask_scheme_select) begin
			// RULE_01 RULE_09 global mask only
			cand_allowed = cand_valid && !flags_reg.global_mask;
		end else if (!flags_reg.global_mask) begin
			// RULE_02 RULE_12 global mask clear
			cand_allowed = cand_valid;
		end else begin
			// RULE_10 RULE_11 two level masking
			cand_allowed = cand_valid && priority_level_bits[cand_id] && !flags_reg.user_mask;
		end
	end

	// RULE_20 RULE_23 access phase length
	always_comb begin
		unique case (mem_kind)
			MEM_EXT8_2: phase_len = PHASE_EXT2 + CNT_W'(wait_states) * WAIT_ACCESS;
			MEM_EXT8_3: phase_len = PHASE_EXT3 + CNT_W'(wait_states) * WAIT_ACCESS;
			default:    phase_len = PHASE_ONCHIP;
		endcase
	end

	assign sel_vector = sel_nmi_reg ? NMI_VECTOR : SRC_VECTORS[8*sel_id_reg +: 8];

	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		flags_next    = flags_reg;
		nmi_pend_next = nmi_pend_reg | nmi_event;
		sel_nmi_next  = sel_nmi_reg;
		sel_id_next   = sel_id_reg;
		frame_next    = frame_reg;
		handler_next  = handler_reg;
		push_next     = 1'b0;
		vread_next    = 1'b0;
		vaddr_next    = vaddr_reg;
		pcld_next     = 1'b0;
		acc_next      = 1'b0;
		if (flags_write) begin
			flags_next = flags_wdata;
		end
		unique case (state_reg)
			ST_IDLE: begin
				// RULE_03 nmi bypasses masks
				if (nmi_pend_next && !standby) begin
					sel_nmi_next = 1'b1;
					state_next   = ST_DECIDE;
					cnt_next     = DECIDE_EXT - 6'h01;
				end else if (cand_valid) begin
					// RULE_18 decision length
					sel_nmi_next = 1'b0;
					sel_id_next  = cand_id;
					state_next   = ST_DECIDE;
					cnt_next     = (SRC_EXTERNAL[cand_id] ? DECIDE_EXT : DECIDE_INT) - 6'h01;
				end
			end
			ST_DECIDE: begin
				// Standby also drops a nonmaskable request already under decision.
				if (sel_nmi_reg ? standby : (!cand_valid || cand_id != sel_id_reg)) begin
					state_next = ST_IDLE;
				end else if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else if (sel_nmi_reg || cand_allowed) begin
					acc_next   = 1'b1;
					state_next = ST_WAIT;
					if (sel_nmi_reg) begin
						nmi_pend_next = nmi_event;
					end
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_WAIT: begin
				// RULE_13 RULE_19 wait for instruction end
				if (insn_done) begin
					frame_next = '{program_counter: return_pc, flags: flags_next};
					state_next = ST_INT_A;
					cnt_next   = INTERNAL_A - 6'h01;
				end
			end
			ST_INT_A: begin
				// RULE_22 internal processing first half
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else begin
					state_next = ST_SAVE;
					push_next  = 1'b1;
					cnt_next   = phase_len - 6'h01;
				end
			end
			ST_SAVE: begin
				// RULE_14 stack save phase
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else begin
					// RULE_15 RULE_16 raise masks after save
					flags_next.global_mask = 1'b1;
					if (!mask_scheme_select) begin
						flags_next.user_mask = 1'b1;
					end
					state_next = ST_VECTOR;
					vread_next = 1'b1;
					vaddr_next = VADDR_W'({sel_vector, VEC_SHIFT'(0)});
					cnt_next   = phase_len - 6'h01;
				end
			end
			ST_VECTOR: begin
				// RULE_17 vector fetch
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else begin
					handler_next = vector_data;
					state_next   = ST_FETCH;
					cnt_next     = phase_len - 6'h01;
				end
			end
			ST_FETCH: begin
				// RULE_21 prefetch phase
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else begin
					state_next = ST_INT_B;
					cnt_next   = INTERNAL_B - 6'h01;
				end
			end
			ST_INT_B: begin
				// RULE_22 internal processing second half
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else begin
					pcld_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
		endcase
		// Standby discards any latched nonmaskable event.
		if (standby) begin
			nmi_pend_next = 1'b0;
		end
		busy_next = state_next != ST_IDLE;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= '0;
			flags_reg    <= FLAGS_RESET;
			nmi_pend_reg <= 1'b0;
			sel_nmi_reg  <= 1'b0;
			sel_id_reg   <= '0;
			frame_reg    <= '0;
			handler_reg  <= '0;
			push_reg     <= 1'b0;
			vread_reg    <= 1'b0;
			vaddr_reg    <= '0;
			pcld_reg     <= 1'b0;
			acc_reg      <= 1'b0;
			busy_reg     <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			flags_reg    <= flags_next;
			nmi_pend_reg <= nmi_pend_next;
			sel_nmi_reg  <= sel_nmi_next;
			sel_id_reg   <= sel_id_next;
			frame_reg    <= frame_next;
			handler_reg  <= handler_next;
			push_reg     <= push_next;
			vread_reg    <= vread_next;
			vaddr_reg    <= vaddr_next;
			pcld_reg     <= pcld_next;
			acc_reg      <= acc_next;
			busy_reg     <= busy_next;
		end
	end

	assign condition_flags = flags_reg;
	assign cpu_request     = busy_reg;
	assign stack_push      = push_reg;
	assign stack_frame     = frame_reg;
	assign vector_read     = vread_reg;
	assign vector_addr     = vaddr_reg;
	assign pc_load         = pcld_reg;
	assign new_pc          = handler_reg;
	assign accept_valid    = acc_reg;
	assign accept_nmi      = sel_nmi_reg;
	assign accept_id       = sel_id_reg;

	chk_nmi_standby: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
		standby |=> !nmi_pend_reg) else $error("nmi pending survived standby");
	chk_standby_accept: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
		standby && sel_nmi_reg |=> !acc_reg) else $error("nmi accepted in standby");
	chk_single_mask: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
		state_reg == ST_DECIDE && cnt_reg == '0 && !sel_nmi_reg && mask_scheme_select
		&& flags_reg.global_mask |=> !acc_reg) else $error("masked request accepted");
	chk_level_zero: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
		state_reg == ST_DECIDE && cnt_reg == '0 && !sel_nmi_reg && flags_reg.global_mask
		&& !priority_level_bits[sel_id_reg] |=> !acc_reg) else $error("level 0 not masked");
	chk_insn_wait: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
		state_reg == ST_WAIT && !insn_done |=> state_reg == ST_WAIT) else $error("left wait early");
	chk_mask_raise: assert property (@(posedge core_clk) disable iff (reset) // RULE_15
		$rose(vread_reg) |-> flags_reg.global_mask
		&& (mask_scheme_select || flags_reg.user_mask)) else $error("masks not raised");
	chk_int_decide: assert property (@(posedge core_clk) disable iff (reset) // RULE_18
		state_reg == ST_IDLE && state_next == ST_DECIDE && !sel_nmi_next
		&& !SRC_EXTERNAL[sel_id_next] |=> cnt_reg == '0) else $error("internal decide length");
	chk_ext_decide: assert property (@(posedge core_clk) disable iff (reset) // RULE_18
		state_reg == ST_IDLE && state_next == ST_DECIDE && (sel_nmi_next
		|| SRC_EXTERNAL[sel_id_next]) |=> cnt_reg == 6'h01) else $error("external decide length");
	chk_push_order: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
		push_reg |-> ##[1:28] vread_reg) else $error("vector fetch missing after push");
	chk_onchip_save: assert property (@(posedge core_clk) disable iff (reset) // RULE_20
		push_reg && mem_kind == MEM_ONCHIP |-> ##4 vread_reg) else $error("onchip save length");
	chk_pc_load: assert property (@(posedge core_clk) disable iff (reset) // RULE_17
		vread_reg && mem_kind == MEM_ONCHIP |-> ##10 pcld_reg) else $error("handler start late");
endmodule : irq_accept

// *** include/irq_accept_pkg.sv ***
// Constants, types and carriers shared by the interrupt acceptance logic.
// Contract
// RULE_01 - Select bit 1: maskable requests gated by the global mask only.
// RULE_02 - Select bit 0: maskable requests gated by global and user-level masks.
// RULE_03 - Nonmaskable request always accepted except in reset or hardware standby.
// RULE_04 - Each source has an enable bit; disabled sources raise no request.
// RULE_05 - Priority level 1 requests are served before level 0 requests.
// RULE_06 - Select the single highest request, keep all others pending.
// RULE_07 - Ties between equal levels are broken by the fixed source order.
// RULE_08 - Smaller vector number wins in the fixed order, which holds after reset.
// RULE_09 - Single-mask scheme, global mask 1: only nonmaskable accepted, rest pending.
// RULE_10 - Two-level scheme: level 0 blocked when global mask is 1.
// RULE_11 - Two-level scheme: level 1 blocked only when both masks are 1.
// RULE_12 - Two-level scheme, global mask 0: selected request accepted regardless.
// RULE_13 - Exception handling starts only after the current instruction completes.
// RULE_14 - Entry pushes return address and flags; return address is next instruction.
// RULE_15 - Single-mask scheme: after saving, set the global mask to 1.
// RULE_16 - Two-level scheme: after saving, set both mask flags to 1.
// RULE_17 - Generate vector address, read handler address, start executing there.
// RULE_18 - Priority decision takes 2 states external, 1 state internal.
// RULE_19 - Instruction end wait is up to 23, 27 or 31 states by memory.
// RULE_20 - Save, vector fetch and prefetch take 4, 8 or 12 states each.
// RULE_21 - Prefetch phase covers one prefetch plus the handler's first fetch.
// RULE_22 - Internal processing takes 4 states, split around the prefetch.
// RULE_23 - External wait states lengthen the external-bus state counts.
// RULE_24 - Pending requests are re-evaluated each cycle until accepted or withdrawn.
package irq_accept_pkg;
	localparam int           N_SRC            = 16;
	localparam int           PC_W             = 24;
	localparam int           VADDR_W          = 16;
	localparam int           CNT_W            = 6;
	localparam int           ID_W             = 4;
	// Vector numbers of the maskable sources, index 0 in the low byte.
	localparam logic [127:0] SRC_VECTORS      = 128'h21_20_1E_1D_1C_1A_19_18_15_14_11_10_0F_0E_0D_0C;
	localparam logic [7:0]   NMI_VECTOR       = 8'h07;
	localparam logic [15:0]  SRC_EXTERNAL     = 16'h003F;
	localparam logic [CNT_W-1:0] DECIDE_EXT   = 6'h02;
	localparam logic [CNT_W-1:0] DECIDE_INT   = 6'h01;
	localparam logic [CNT_W-1:0] PHASE_ONCHIP = 6'h04;
	localparam logic [CNT_W-1:0] PHASE_EXT2   = 6'h08;
	localparam logic [CNT_W-1:0] PHASE_EXT3   = 6'h0C;
	localparam logic [CNT_W-1:0] WAIT_ACCESS  = 6'h04;
	localparam logic [CNT_W-1:0] INTERNAL_A   = 6'h02;
	localparam logic [CNT_W-1:0] INTERNAL_B   = 6'h02;
	localparam int           VEC_SHIFT        = 2;

	typedef struct packed {
		logic       global_mask;
		logic       user_mask;
		logic [5:0] other;
	} flags_type;

	localparam flags_type FLAGS_RESET = 8'h80;

	typedef struct packed {
		logic [PC_W-1:0] program_counter;
		flags_type       flags;
	} frame_type;

	typedef enum logic [1:0] {
		MEM_ONCHIP = 2'b00,
		MEM_EXT8_2 = 2'b01,
		MEM_EXT8_3 = 2'b10
	} mem_type;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DECIDE = 3'b001,
		ST_WAIT   = 3'b010,
		ST_INT_A  = 3'b011,
		ST_SAVE   = 3'b100,
		ST_VECTOR = 3'b101,
		ST_FETCH  = 3'b110,
		ST_INT_B  = 3'b111
	} state_type;
endpackage : irq_accept_pkg

// *** sim/cpu_core_model.sv ***
// Behavioural core partner: completes instructions and serves the vector table.
`timescale 1ns/10ps
module cpu_core_model
	import irq_accept_pkg::*;
(
	input  wire logic                                core_clk,
	input  wire logic                                reset,
	input  wire logic [irq_accept_pkg::VADDR_W-1:0]  vector_addr,
	output logic                                     insn_done,
	output logic [irq_accept_pkg::PC_W-1:0]          return_pc,
	output logic [irq_accept_pkg::PC_W-1:0]          vector_data
);
	import irq_accept_pkg::*;

	logic [4:0]      gap_reg;
	logic [PC_W-1:0] pc_reg;

	// Outside its strobe the return address shows the inverted value, so a stale sample shows.
	assign return_pc   = insn_done ? pc_reg : ~pc_reg;
	assign vector_data = {8'h01, vector_addr ^ 16'h5A5A};

	always @(negedge core_clk or posedge reset) begin
		if (reset) begin
			gap_reg   <= 5'h01;
			pc_reg    <= 24'h000100;
			insn_done <= 1'b0;
		end else begin
			insn_done <= (gap_reg == 5'h00);
			if (gap_reg == 5'h00) begin
				gap_reg <= 5'($urandom_range(1, 23));
				pc_reg  <= pc_reg + 24'h000002;
			end else begin
				gap_reg <= gap_reg - 5'h01;
			end
		end
	end
endmodule : cpu_core_model

// *** sim/irq_accept_tb_top.sv ***
// Self-checking bench for the interrupt acceptance block.
`timescale 1ns/10ps
module irq_accept_tb_top;
	import irq_accept_pkg::*;
	logic               core_clk, reset, standby, nmi_event, mask_scheme_select, flags_write;
	logic [N_SRC-1:0]   src_flag, src_enable, priority_level_bits;
	logic [1:0]         wait_states;
	mem_type            mem_kind;
	flags_type          flags_wdata, condition_flags;
	logic               insn_done, cpu_request, stack_push, vector_read, pc_load;
	logic               accept_valid, accept_nmi;
	logic               armed = 1'b0;
	logic [PC_W-1:0]    return_pc, vector_data, new_pc, pc_q;
	frame_type          stack_frame, frame_q;
	logic [VADDR_W-1:0] vector_addr;
	logic [ID_W-1:0]    accept_id;
	logic [ID_W-1:0]    id_q;
	logic               nmi_q;
	int                 fails = 0, n_compared = 0, cyc = 0, n_acc = 0;
	int                 t_acc = 0, t_done = 0, t_push = 0, t_vec = 0, t_load = 0;
	// Vector number of each maskable source, in input bit order.
	localparam logic [7:0] VEC [N_SRC] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14,
		8'h15, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21};

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	irq_accept     uut (.*);
	cpu_core_model core (.*);

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (accept_valid) begin
			t_acc <= cyc;
			n_acc <= n_acc + 1;
			nmi_q <= accept_nmi;
			id_q  <= accept_id;
		end
		if (insn_done && (armed || accept_valid)) begin
			t_done <= cyc;
			pc_q   <= return_pc;
		end
		armed <= !insn_done && (armed || accept_valid);
		if (stack_push) begin
			t_push  <= cyc;
			frame_q <= stack_frame;
		end
		if (vector_read) t_vec <= cyc;
		if (pc_load) t_load <= cyc;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize

	// Level 1 first, then the lowest input index, which carries the smallest vector.
	function automatic int pick(input logic [N_SRC-1:0] req, input logic [N_SRC-1:0] lvl);
		for (int i = 0; i < N_SRC; i++) if (req[i] && lvl[i]) return i;
		for (int i = 0; i < N_SRC; i++) if (req[i]) return i;
		return -1;
	endfunction : pick

	task automatic trial(input logic [N_SRC-1:0] fl, en, lv, input logic sch, gm, um, nmi);
		int              sel, ph, t0, n0, k;
		logic            ok;
		logic [15:0]     va;
		flags_type       f;
		sel = pick(fl & en, lv);
		ok  = nmi || (sel >= 0 && (!gm || (!sch && !um && lv[sel] === 1'b1)));
		f   = '{global_mask: gm, user_mask: um, other: 6'h00};
		va  = 16'((nmi ? 7 : VEC[sel]) * 4);
		mem_kind    = mem_type'($urandom_range(0, 2));
		wait_states = 2'($urandom);
		ph = (mem_kind == MEM_ONCHIP) ? 4 : ((mem_kind == MEM_EXT8_2) ? 8 : 12) + 4 * wait_states;
		src_enable          = en;
		priority_level_bits = lv;
		mask_scheme_select  = sch;
		flags_write         = 1'b1;
		flags_wdata         = f;
		@(negedge core_clk);
		flags_write = 1'b0;
		src_flag    = fl;
		nmi_event   = nmi;
		t0          = cyc;
		n0          = n_acc;
		@(negedge core_clk);
		nmi_event = 1'b0;
		check(cpu_request, nmi || sel >= 0);
		if (!ok) begin
			repeat (12) @(negedge core_clk);
			check(n_acc - n0, 0);
			if (sel < 0) begin
				src_flag = '0;
				$display("trial done at %0t", $time);
				return;
			end
			f.global_mask = 1'b0;
			flags_write   = 1'b1;
			flags_wdata   = f;
			@(negedge core_clk);
			flags_write = 1'b0;
		end
		for (k = 0; k < 300 && t_load < t0; k++) @(negedge core_clk);
		check(k >= 300, 0);
		check(nmi_q, nmi);
		if (!nmi) check(id_q, sel);
		if (ok) check(t_acc - t0, (nmi || sel < 6) ? 3 : 2);
		check(vector_addr, va);
		check(new_pc, {8'h01, va ^ 16'h5A5A});
		check(frame_q, {pc_q, f});
		check(t_push - t_done, 3);
		check(t_vec - t_push, ph);
		check(t_load - t_vec, 2 * ph + 2);
		check(condition_flags, {1'b1, sch ? um : 1'b1, 6'h00});
		src_flag = '0;
		repeat (3) @(negedge core_clk);
		check(cpu_request, 0);
		$display("trial done at %0t", $time);
	endtask : trial

	initial begin
		{standby, nmi_event, flags_write, mask_scheme_select} = 4'h0;
		src_flag            = '0;
		src_enable          = '0;
		priority_level_bits = '0;
		flags_wdata         = 8'h00;
		mem_kind            = MEM_ONCHIP;
		wait_states         = 2'h0;
		reset               = 1'b1;
		void'($urandom(82));
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		trial('1, '1, '0, 1'b1, 1'b0, 1'b0, 1'b0);
		trial('1, '1, 16'h8000, 1'b0, 1'b0, 1'b1, 1'b0);
		trial(16'h0003, 16'h0002, '0, 1'b1, 1'b0, 1'b0, 1'b0);
		trial(16'h0F00, '1, 16'h0400, 1'b0, 1'b1, 1'b0, 1'b0);
		trial(16'h0F00, '1, 16'h0400, 1'b0, 1'b1, 1'b1, 1'b0);
		trial(16'h00F0, '1, 16'h0010, 1'b1, 1'b1, 1'b0, 1'b0);
		trial(16'h00F0, '1, '0, 1'b0, 1'b1, 1'b0, 1'b0);
		trial('0, '1, '0, 1'b0, 1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 60; i++) begin
			trial(16'($urandom), 16'($urandom), 16'($urandom), 1'($urandom), 1'($urandom),
				1'($urandom), ($urandom_range(0, 7) == 0));
		end
		standby   = 1'b1;
		nmi_event = 1'b1;
		k_wait(n_acc);
		summarize();
	end

	// A nonmaskable edge during hardware standby must never be taken, even after leaving it.
	task automatic k_wait(input int n0);
		@(negedge core_clk);
		nmi_event = 1'b0;
		repeat (12) @(negedge core_clk);
		standby = 1'b0;
		repeat (12) @(negedge core_clk);
		check(n_acc - n0, 0);
		$display("standby test done at %0t", $time);
	endtask : k_wait

	initial begin
		#(50 * 40000);
		fails++;
		summarize();
	end
endmodule : irq_accept_tb_top
